/* File: core/scfm_pkg.sv */
// Shared constants and types for the serial CMOS frame and mapper config
package scfm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_BCK = 6'h18;
  localparam logic [5:0] IDX_FRM = 6'h19;
  localparam logic [5:0] IDX_MAP = 6'h1b;
  localparam logic [5:0] IDX_BCK2 = 6'h1f;
  localparam logic [5:0] IDX_MODE = 6'h30;
  localparam logic [5:0] IDX_STAT = 6'h31;
  // Field positions
  localparam int BCK_EN_BIT = 4;
  localparam int BCK2_EN_BIT = 6;
  localparam int FRM_SRC_BIT = 7;
  localparam int FRM_DIV_BIT = 4;
  localparam int FRM_OE_BIT = 1;
  localparam int FRM_STR_BIT = 0;
  localparam int MAP_EN_BIT = 7;
  localparam int MAP_20_BIT = 6;
  localparam int MAP_RES_LSB = 3;
  localparam int MODE_DEC_LSB = 0;
  localparam int MODE_WIRE_LSB = 2;
  // Writable bits; all others are reserved and hold zero
  localparam logic [7:0] BCK_MASK = 8'h10;
  localparam logic [7:0] FRM_MASK = 8'h93;
  localparam logic [7:0] MAP_MASK = 8'hf8;
  localparam logic [7:0] BCK2_MASK = 8'h40;
  localparam logic [7:0] MODE_MASK = 8'h0f;
  // Reset values
  localparam logic [7:0] BCK_RST = 8'h00;
  localparam logic [7:0] FRM_RST = 8'h00;
  localparam logic [7:0] MAP_RST = 8'h00;
  localparam logic [7:0] BCK2_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  // Resolution select codes
  localparam logic [2:0] RES_CODE_18 = 3'h0;
  localparam logic [2:0] RES_CODE_16 = 3'h1;
  localparam logic [2:0] RES_CODE_14 = 3'h2;
  // Word widths in bits
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_18 = 5'h12;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_14 = 5'h0e;
  // Decimation and serialization mode codes
  localparam logic [1:0] DEC_BYPASS = 2'h0;
  localparam logic [1:0] DEC_REAL = 2'h1;
  localparam logic [1:0] DEC_COMPLEX = 2'h2;
  localparam logic [1:0] WIRE_2 = 2'h0;
  localparam logic [1:0] WIRE_1 = 2'h1;
  localparam logic [1:0] WIRE_HALF = 2'h2;
  // Status register layout
  localparam int STAT_BUF_BIT = 0;
  localparam int STAT_RES_LSB = 1;
  localparam int STAT_UNSUP_BIT = 6;
  localparam int STAT_FRM_BIT = 7;

  typedef enum logic {FG_IDLE, FG_RUN} scfm_fg_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scfm_wb_req_t;
endpackage

/* File: core/scfm_sync2.sv */
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module scfm_sync2
  import scfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async,
  output logic sync
);
  typedef struct packed {
    logic meta;
    logic stable;
  } scfm_sync_t;

  scfm_sync_t s;
  scfm_sync_t next_s;

  always_comb
  begin
    next_s.meta = async;
    next_s.stable = s.meta;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync = s.stable;
endmodule

/* File: core/scfm_frame_gen.sv */
// Frame clock generator counting edges of the bit clock from the capture host
`timescale 1ns/1ps
module scfm_frame_gen
  import scfm_pkg::*;
#(
  parameter int CW = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic edgeHit,
  input wire logic [CW-1:0] halfPeriod,
  output logic frameClk
);
  typedef struct packed {
    scfm_fg_state_t st;
    logic [CW-1:0] cnt;
    logic lvl;
  } scfm_fg_t;

  scfm_fg_t s;
  scfm_fg_t next_s;

  always_comb
  begin
    next_s = s;
    case (s.st)
      FG_IDLE:
      begin
        next_s.cnt = '0;
        next_s.lvl = 1'b0;
        if (run)
          next_s.st = FG_RUN;
      end
      FG_RUN:
      begin
        if (!run)
          next_s.st = FG_IDLE;
        else if (edgeHit)
        begin
          if (s.cnt + 1'b1 >= halfPeriod)
          begin
            next_s.cnt = '0;
            next_s.lvl = ~s.lvl;
          end
          else
            next_s.cnt = s.cnt + 1'b1;
        end
      end
      default:
        next_s.st = FG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '{st: FG_IDLE, cnt: '0, lvl: 1'b0};
    else
      s <= next_s;
  end

  assign frameClk = s.lvl;

  // In FG_RUN the level moves only on a counted bit clock edge; FG_IDLE clears it
  AST_FG_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    (s.st == FG_RUN && $past(s.st) == FG_RUN && $changed(s.lvl))
      |-> $past(edgeHit))
    else $error("frame clock moved without a bit clock edge");
endmodule

/* File: core/scfm_cfg.sv */
// Register bank for bit clock input, frame clock and output bit mapper
`timescale 1ns/1ps
module scfm_cfg
  import scfm_pkg::*;
#(
  parameter int CW = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire scfm_wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDat,
  input wire logic bitClockInput,
  input wire logic filterFrameClock,
  input wire logic parallelDataBit,
  output logic sharedPinOut,
  output logic bitClockBufferOn,
  output logic [4:0] outputBits
);
  typedef struct packed {
    logic [7:0] bck;
    logic [7:0] frm;
    logic [7:0] map;
    logic [7:0] bck2;
    logic [7:0] mode;
    logic ack;
    logic [31:0] rdat;
    logic bufOn;
    logic [4:0] resBits;
    logic unsup;
    logic pin;
    logic lastBit;
    logic edgeHit;
  } scfm_cfg_t;

  scfm_cfg_t s;
  scfm_cfg_t next_s;
  logic bitClkSync;
  logic genFrame;
  logic [CW-1:0] halfPeriod;

  // Local decode of the configuration
  logic bothEn;
  logic srcFilter;
  logic oe;
  logic [1:0] decMode;
  logic [1:0] wireMode;
  logic [2:0] resCode;
  logic frameSel;
  logic [4:0] resNext;
  logic unsupNext;
  logic hit;
  logic [5:0] idx;
  logic [7:0] rbyte;
  logic [7:0] stat;

  scfm_sync2 u_bit_clk_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async(bitClockInput),
    .sync(bitClkSync)
  );

  scfm_frame_gen #(.CW(CW)) u_frame_gen (
    .core_clk(core_clk),
    .rst(rst),
    .run(s.bufOn),
    .edgeHit(s.edgeHit),
    .halfPeriod(halfPeriod),
    .frameClk(genFrame)
  );

  always_comb
  begin
    decMode = s.mode[MODE_DEC_LSB +: 2];
    wireMode = s.mode[MODE_WIRE_LSB +: 2];
    resCode = s.map[MAP_RES_LSB +: 3];
    oe = s.frm[FRM_OE_BIT];
    bothEn = s.bck[BCK_EN_BIT] & s.bck2[BCK2_EN_BIT];
    // source gating
    // Filter source only in complex modes other than half-wire; real acts as bypass
    srcFilter = s.frm[FRM_SRC_BIT] && decMode == DEC_COMPLEX
      && wireMode != WIRE_HALF;
    frameSel = srcFilter ? filterFrameClock : genFrame;
  end

  // Resolution chosen by the mapper and the decimation mode
  always_comb
  begin
    resNext = BITS_14;
    unsupNext = 1'b0;
    if (s.map[MAP_20_BIT])
      resNext = BITS_20;
    else if (decMode == DEC_BYPASS)
    begin
      if (s.map[MAP_EN_BIT])
      begin
        case (resCode)
          RES_CODE_18: resNext = BITS_18;
          RES_CODE_16: resNext = BITS_16;
          RES_CODE_14: resNext = BITS_14;
          default: unsupNext = 1'b1;
        endcase
      end
    end
    else
    begin
      resNext = (decMode == DEC_COMPLEX) ? BITS_16 : BITS_18;
      if (s.map[MAP_EN_BIT] || resCode != RES_CODE_18)
      begin
        case (resCode)
          RES_CODE_18: resNext = BITS_18;
          RES_CODE_16: resNext = BITS_16;
          RES_CODE_14: resNext = BITS_14;
          default: unsupNext = 1'b1;
        endcase
      end
    end
  end

  // Frame clock half period in bit clock edges (both edges count)
  always_comb
  begin
    halfPeriod = CW'(s.resBits);
    case (wireMode)
      WIRE_2: halfPeriod = CW'(s.resBits >> 1);
      WIRE_HALF: halfPeriod = CW'({s.resBits, 1'b0});
      default: halfPeriod = CW'(s.resBits);
    endcase
    if (s.frm[FRM_DIV_BIT])
      halfPeriod = halfPeriod << 1;
    if (s.frm[FRM_STR_BIT])
      halfPeriod = halfPeriod << 1;
  end

  always_comb
  begin
    stat = '0;
    stat[STAT_BUF_BIT] = s.bufOn;
    stat[STAT_RES_LSB +: 5] = s.resBits;
    stat[STAT_UNSUP_BIT] = s.unsup;
    stat[STAT_FRM_BIT] = frameSel;
    idx = wbReq.adr[7:2];
    case (idx)
      IDX_BCK: rbyte = s.bck;
      IDX_FRM: rbyte = s.frm;
      IDX_MAP: rbyte = s.map;
      IDX_BCK2: rbyte = s.bck2;
      IDX_MODE: rbyte = s.mode;
      IDX_STAT: rbyte = stat;
      default: rbyte = '0;
    endcase
  end

  always_comb
  begin
    next_s = s;
    hit = wbReq.cyc && wbReq.stb && !s.ack;
    next_s.ack = hit;
    if (hit)
    begin
      next_s.rdat = {24'h000000, rbyte};
      if (wbReq.we && wbReq.sel[0])
      begin
        case (idx)
          IDX_BCK: next_s.bck = wbReq.dat[7:0] & BCK_MASK;
          IDX_FRM: next_s.frm = wbReq.dat[7:0] & FRM_MASK;
          IDX_MAP: next_s.map = wbReq.dat[7:0] & MAP_MASK;
          IDX_BCK2: next_s.bck2 = wbReq.dat[7:0] & BCK2_MASK;
          IDX_MODE: next_s.mode = wbReq.dat[7:0] & MODE_MASK;
          default: next_s.rdat = s.rdat;
        endcase
      end
    end
    next_s.bufOn = bothEn;
    next_s.lastBit = bitClkSync;
    next_s.edgeHit = s.bufOn && (bitClkSync != s.lastBit);
    next_s.resBits = resNext;
    next_s.unsup = unsupNext;
    next_s.pin = oe ? frameSel : parallelDataBit;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.bck <= BCK_RST;
      s.frm <= FRM_RST;
      s.map <= MAP_RST;
      s.bck2 <= BCK2_RST;
      s.mode <= MODE_RST;
      s.resBits <= BITS_14;
    end
    else
      s <= next_s;
  end

  assign wbAck = s.ack;
  assign wbDat = s.rdat;
  assign sharedPinOut = s.pin;
  assign bitClockBufferOn = s.bufOn;
  assign outputBits = s.resBits;

  // Ack is a single-cycle pulse per request
  AST_ACK_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");

  // Request answered one cycle after it is seen
  AST_ACK_LATENCY: assert property (@(posedge core_clk) disable iff (rst)
    (wbReq.cyc && wbReq.stb && !s.ack) |=> s.ack)
    else $error("request not answered in one cycle");

  AST_BUF_BOTH: assert property (@(posedge core_clk) disable iff (rst)
    s.bufOn == $past(s.bck[BCK_EN_BIT] && s.bck2[BCK2_EN_BIT]))
    else $error("buffer state does not follow both enables");

  AST_BUF_GATE: assert property (@(posedge core_clk) disable iff (rst)
    !s.bufOn |=> !s.edgeHit)
    else $error("bit clock edge counted while buffer off");

  AST_SRC_FILTER: assert property (@(posedge core_clk)
    disable iff (rst)
    (oe && srcFilter) |=> s.pin == $past(filterFrameClock))
    else $error("pin not carrying filter frame clock");

  AST_SRC_REAL: assert property (@(posedge core_clk) disable iff (rst)
    (oe && decMode != DEC_COMPLEX) |=> s.pin == $past(genFrame))
    else $error("bypass or real mode not using core frame clock");

  AST_PIN_DATA: assert property (@(posedge core_clk) disable iff (rst)
    !oe |=> s.pin == $past(parallelDataBit))
    else $error("pin not carrying parallel data");

  AST_RES_20: assert property (@(posedge core_clk) disable iff (rst)
    s.map[MAP_20_BIT] |=> s.resBits == BITS_20)
    else $error("twenty-bit enable ignored");

  AST_MAP_OFF: assert property (@(posedge core_clk) disable iff (rst)
    (decMode == DEC_BYPASS && !s.map[MAP_EN_BIT] && !s.map[MAP_20_BIT])
      |=> s.resBits == BITS_14)
    else $error("bypass resolution changed without mapper");

  AST_RES_14: assert property (@(posedge core_clk) disable iff (rst)
    (s.map[MAP_EN_BIT] && !s.map[MAP_20_BIT] && resCode == RES_CODE_14)
      |=> s.resBits == BITS_14 && !s.unsup)
    else $error("code 010 did not give 14 bits");

  AST_CPLX_DEF: assert property (@(posedge core_clk)
    disable iff (rst)
    (decMode == DEC_COMPLEX && s.map[MAP_EN_BIT:MAP_RES_LSB] == 5'h00)
      |=> s.resBits == BITS_16)
    else $error("complex default is not 16 bits");

  AST_REAL_DEF: assert property (@(posedge core_clk)
    disable iff (rst)
    (decMode == DEC_REAL && s.map[MAP_EN_BIT:MAP_RES_LSB] == 5'h00)
      |=> s.resBits == BITS_18)
    else $error("real default is not 18 bits");

  AST_RES_18: assert property (@(posedge core_clk)
    disable iff (rst)
    (s.map[MAP_EN_BIT] && !s.map[MAP_20_BIT] && resCode == RES_CODE_18)
      |=> s.resBits == BITS_18 && !s.unsup)
    else $error("code 000 did not give 18 bits");

  AST_RES_16: assert property (@(posedge core_clk)
    disable iff (rst)
    (s.map[MAP_EN_BIT] && !s.map[MAP_20_BIT] && resCode == RES_CODE_16)
      |=> s.resBits == BITS_16 && !s.unsup)
    else $error("code 001 did not give 16 bits");

  AST_UNSUP_CODE: assert property (@(posedge core_clk)
    disable iff (rst)
    (s.map[MAP_EN_BIT] && !s.map[MAP_20_BIT] && resCode > RES_CODE_14)
      |=> s.unsup)
    else $error("unsupported code not flagged");

  // Half-wire complex keeps the core frame clock whatever source says
  AST_SRC_HALF: assert property (@(posedge core_clk)
    disable iff (rst)
    (oe && decMode == DEC_COMPLEX && wireMode == WIRE_HALF)
      |=> s.pin == $past(genFrame))
    else $error("half-wire complex not using core frame clock");

  AST_GEN_IDLE: assert property (@(posedge core_clk)
    disable iff (rst)
    !s.bufOn ##1 !s.bufOn |=> !genFrame)
    else $error("frame clock runs while buffer off");

  AST_RSV_ZERO: assert property (@(posedge core_clk)
    disable iff (rst)
    (s.bck & ~BCK_MASK) == 8'h00 && (s.frm & ~FRM_MASK) == 8'h00
      && (s.map & ~MAP_MASK) == 8'h00 && (s.bck2 & ~BCK2_MASK) == 8'h00)
    else $error("reserved bit holds a one");

  AST_WR_MASK: assert property (@(posedge core_clk)
    disable iff (rst)
    (hit && wbReq.we && wbReq.sel[0] && idx == IDX_FRM)
      |=> s.frm == ($past(wbReq.dat[7:0]) & FRM_MASK))
    else $error("frame register write not masked");

  AST_ACK_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    !(wbReq.cyc && wbReq.stb) |=> !s.ack)
    else $error("ack without a request");

  AST_DIV_1W: assert property (@(posedge core_clk)
    disable iff (rst)
    (s.frm[FRM_DIV_BIT] && !s.frm[FRM_STR_BIT] && wireMode == WIRE_1)
      |-> halfPeriod == CW'({s.resBits, 1'b0}))
    else $error("divide did not double the frame span");

  AST_STR_HALF: assert property (@(posedge core_clk)
    disable iff (rst)
    (s.frm[FRM_STR_BIT] && !s.frm[FRM_DIV_BIT] && wireMode == WIRE_HALF)
      |-> halfPeriod == CW'({s.resBits, 2'b00}))
    else $error("half-wire stretch span wrong");

  AST_STRETCH: assert property (@(posedge core_clk) disable iff (rst)
    (s.frm[FRM_STR_BIT] && !s.frm[FRM_DIV_BIT] && wireMode == WIRE_1)
      |-> halfPeriod == CW'({s.resBits, 1'b0}))
    else $error("stretch did not double the frame span");
endmodule

/* File: tb/scfm_bitclk_host.sv */
// Capture host model: makes the bit clock, measures frame clock spans
`timescale 1ns/1ps
module scfm_bitclk_host
  import scfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic run,
  input wire logic sharedPinOut,
  output logic bitClk,
  output int lastSpan
);
  int edgeCnt;
  logic prevBit = 1'b0;
  logic pinSeen;
  // Clock stands still while run is low; phase offset keeps it off core edges
  initial
  begin
    bitClk = 1'b0;
    #37;
    forever
    begin
      #80;
      if (run)
        bitClk = ~bitClk;
    end
  end
  // Spans are counted in bit clock edges between frame level changes
  always @(posedge core_clk)
  begin
    prevBit <= bitClk;
    pinSeen <= sharedPinOut;
    if (pinSeen !== sharedPinOut)
    begin
      lastSpan <= edgeCnt;
      edgeCnt <= int'(prevBit !== bitClk);
    end
    else
      edgeCnt <= edgeCnt + int'(prevBit !== bitClk);
  end
endmodule

/* File: tb/tb_scfm_cfg.sv */
// Self-checking bench for the frame clock and mapper register bank
`timescale 1ns/1ps
module tb_scfm_cfg
  import scfm_pkg::*;
;
  logic core_clk, rst, wbAck, bitClk, run;
  logic filterFrameClock, parallelDataBit, sharedPinOut, bitClockBufferOn;
  scfm_wb_req_t wbReq;
  logic [31:0] wbDat;
  logic [4:0] outputBits;
  int lastSpan, num_errors, checked, i;
  logic [31:0] expQ[$];
  logic [7:0] tMode [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h02, 8'h01, 8'h0a};
  logic [7:0] tMap [11] = '{8'h00, 8'h88, 8'h80, 8'h90, 8'h08, 8'h98,
    8'h40, 8'h00, 8'h00, 8'h08, 8'h80};
  logic [4:0] tBits [11] = '{BITS_14, BITS_16, BITS_18, BITS_14, BITS_14,
    BITS_14, BITS_20, BITS_18, BITS_16, BITS_16, BITS_18};
  logic [7:0] sMode [4] = '{8'h01, 8'h05, 8'h00, 8'h0a};
  logic [7:0] sFrm [4] = '{8'h02, 8'h02, 8'h12, 8'h03};
  int sSpan [4] = '{9, 18, 14, 64};

  scfm_cfg #(.CW(8)) u_dut (.core_clk(core_clk), .rst(rst), .wbReq(wbReq),
    .wbAck(wbAck), .wbDat(wbDat), .bitClockInput(bitClk),
    .filterFrameClock(filterFrameClock), .parallelDataBit(parallelDataBit),
    .sharedPinOut(sharedPinOut), .bitClockBufferOn(bitClockBufferOn),
    .outputBits(outputBits));
  scfm_bitclk_host u_host (.core_clk(core_clk), .run(run),
    .sharedPinOut(sharedPinOut), .bitClk(bitClk), .lastSpan(lastSpan));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Holds the request until ack is sampled, then releases it
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] d,
    logic [31:0] exp);
    int n;
    n = 0;
    if (!we)
      expQ.push_back(exp);
    @(posedge core_clk);
    wbReq <= '{1'b1, 1'b1, we, adr, 4'h1, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      print_verdict();
    end
    else
      wbReq <= '0;
  endtask

  task automatic wr(logic [7:0] adr, logic [31:0] d);
    wb(1'b1, adr, d, 32'h0);
  endtask

  task automatic rd(logic [7:0] adr, logic [31:0] exp);
    wb(1'b0, adr, 32'h0, exp);
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask

  always @(posedge core_clk)
    if (wbAck === 1'b1 && wbReq.we === 1'b0)
    begin
      if (expQ.size() == 0)
        check("read queue", 32'h1, 32'h0);
      else
        check("wbDat", wbDat, expQ.pop_front());
    end

  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    wbReq = '0;
    run = 1'b0;
    filterFrameClock = 1'b0;
    parallelDataBit = 1'b0;
    void'($urandom(17495));
    tick(16);
    rst <= 1'b0;
    rd(8'h60, 32'h0);
    rd(8'h64, 32'h0);
    rd(8'h6c, 32'h0);
    check("outputBits", outputBits, BITS_14);
    $display("test reset done");
    wr(8'h60, 32'h10);
    wr(8'h64, 32'h02);
    wr(8'h6c, 32'h90);
    wr(8'h10, 32'hff);
    rd(8'h60, 32'h10);
    rd(8'h64, 32'h02);
    rd(8'h6c, 32'h90);
    rd(8'h10, 32'h0);
    wr(8'h64, 32'h0);
    wr(8'h6c, 32'h0);
    $display("test reserved done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h60, i[0] ? 32'h10 : 32'h0);
      wr(8'h7c, i[1] ? 32'h40 : 32'h0);
      tick(2);
      check("bitClockBufferOn", bitClockBufferOn, i == 3);
    end
    $display("test buffer enable done");
    // Host enables the mapper before a code applies in bypass; real mode applies code 001 without it
    for (i = 0; i < 11; i++)
    begin
      wr(8'hc0, tMode[i]);
      wr(8'h6c, tMap[i]);
      tick(2);
      check("outputBits", outputBits, tBits[i]);
    end
    // Status: unsupported code flagged, width 14, buffer on
    wr(8'hc0, 32'h0);
    wr(8'h6c, 32'h98);
    rd(8'hc4, 32'h5d);
    wr(8'h6c, 32'h0);
    $display("test mapper done");
    wr(8'h64, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      parallelDataBit <= 1'($urandom);
      filterFrameClock <= 1'($urandom);
      tick(3);
      check("pin data", sharedPinOut, parallelDataBit);
    end
    // Filter source with complex 2-wire output
    wr(8'hc0, 32'h02);
    wr(8'h64, 32'h82);
    for (i = 0; i < 6; i++)
    begin
      filterFrameClock <= 1'($urandom);
      tick(3);
      check("pin filter", sharedPinOut, filterFrameClock);
    end
    wr(8'h60, 32'h0);
    wr(8'hc0, 32'h01);
    filterFrameClock <= 1'b1;
    tick(8);
    check("pin real", sharedPinOut, 1'b0);
    wr(8'h60, 32'h10);
    $display("test pin mux done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'hc0, sMode[i]);
      wr(8'h64, sFrm[i]);
      run <= 1'b1;
      tick(sSpan[i] * 120 + 200);
      check("frame span", lastSpan, sSpan[i]);
    end
    run <= 1'b0;
    $display("test frame span done");
    print_verdict();
  end
endmodule
